// *** rtl/arc_pkg.sv ***
package arc_pkg;

  ////////////////////////////////////////////////////////////////
  // Timing: one timer tick is 10 ms
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 10000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 20;
  localparam int NUM_STAGES = 10;
  localparam int NUM_CONTACTS = 3;
  localparam int NUM_STATUS = 6;
  localparam int NUM_EVENTS = 4;

  ////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_DEAD1 = 8'h18;
  localparam logic [7:0] OFS_DEAD2 = 8'h1c;
  localparam logic [7:0] OFS_DEAD3 = 8'h20;
  localparam logic [7:0] OFS_DEAD4 = 8'h24;
  localparam logic [7:0] OFS_EWIN = 8'h28;
  localparam logic [7:0] OFS_RECLAIM = 8'h2c;
  localparam logic [7:0] OFS_INHIB = 8'h30;
  localparam logic [7:0] OFS_STAGE = 8'h34;
  localparam logic [7:0] OFS_ROUTE = 8'h38;

  ////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_SVC = 0;
  localparam int CTRL_SHOTS = 1;
  localparam int CTRL_POLICY = 3;
  localparam int CTRL_RELSRC = 4;
  localparam int CTRL_TRIPBLK = 5;
  localparam int CTRL_POL = 10;
  localparam int CMD_ZERO = 0;
  localparam int CMD_RELEASE = 1;

  ////////////////////////////////////////////////////////////////
  // Reset values, intervals in ticks
  localparam logic [TMR_W-1:0] RST_DEAD1 = 20'h003e8;
  localparam logic [TMR_W-1:0] RST_DEAD2 = 20'h01770;
  localparam logic [TMR_W-1:0] RST_DEAD3 = 20'h04650;
  localparam logic [TMR_W-1:0] RST_DEAD4 = 20'h04650;
  localparam logic [TMR_W-1:0] RST_EWIN = 20'h001f4;
  localparam logic [TMR_W-1:0] RST_RECLAIM = 20'h04650;
  localparam logic [TMR_W-1:0] RST_INHIB = 20'h001f4;
  localparam logic [1:0] RST_SHOTS_M1 = 2'h0;
  localparam logic [4:0] RST_TRIPBLK = 5'h1e;
  localparam logic [19:0] RST_STAGE = 20'h00001;

  // Stage choice codes, two bits per stage
  localparam logic [1:0] CH_NONE = 2'h0;
  localparam logic [1:0] CH_START = 2'h1;
  localparam logic [1:0] CH_VETO = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {PH_IDLE, PH_TRIPPED, PH_DEAD, PH_WAIT, PH_CLOSING, PH_RECLAIM,
                            PH_LOCKOUT, PH_INHIBIT} arc_phase_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } arc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } arc_axi_rsp_t;

endpackage : arc_pkg

// *** rtl/arc_in_cond.sv ***
`timescale 1ns/10ps
module arc_in_cond #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Raw contacts and polarity (1 = normally closed)
  input wire logic [WIDTH-1:0] raw,
  input wire logic [WIDTH-1:0] pol,
  // Conditioned, active high
  output logic [WIDTH-1:0] asserted
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } arc_cond_t;

  arc_cond_t c_reg;
  arc_cond_t c_next;

  always_comb begin
    c_next = c_reg;
    c_next.s1 = raw;
    c_next.s2 = c_reg.s1;
    c_next.s3 = c_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // A change counts only once the second and third stages agree
      if (c_reg.s2[i] == c_reg.s3[i]) begin
        c_next.filt[i] = c_reg.s2[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign asserted = c_reg.filt ^ pol;

  property p_filt_follow;
    @(posedge ref_clk) disable iff (!resetn)
    (c_reg.s2 == c_reg.s3) |=> (c_reg.filt == $past(c_reg.s2));
  endproperty
  a_filt_follow: assert property (p_filt_follow) else $error("filtered input missed agreed level");

endmodule : arc_in_cond

// *** rtl/arc_core.sv ***
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// How it works
// - Energy-ok absent for whole wait window after dead interval: lockout, no close.
// - Block input stops new cycles; during a cycle it forces lockout.
// - Lockout release works only once every lockout cause has cleared.
// - Energy, block and release contacts each have selectable polarity.
// - Remote mode selects in/out of service; readable flag, default in service.
// - Count reclose operations; a zeroing command clears the count.
// - Per trip 1..5 setting blocks instantaneous stages; default trip 1 unblocked.
// - Final trip policy: allow tripping (default) or block tripping.
// - Lockout released by interface command (default) or by out-of-service.
// - Each status output routes to a contact or to a monitor bit.
// - Shot limit one to four, each shot with its own dead interval.
// - Each stage: start cycle, no action, or veto reclosing.
// - Dead interval starts on protection reset; close held until breaker closed.
// - Trip in reclaim advances the shot, or locks out when shots used up.
module arc_core #(
  parameter int TICK_CYCLES = arc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register bus
  input wire arc_pkg::arc_axi_req_t axi_req,
  output arc_pkg::arc_axi_rsp_t axi_rsp,
  // Protection stages and breaker status
  input wire logic [arc_pkg::NUM_STAGES-1:0] stage_trip,
  input wire logic breaker_open,
  input wire logic breaker_closed,
  // Contacts: energy ok, block, lockout release
  input wire logic breaker_energy_ok_pin,
  input wire logic block_pin,
  input wire logic release_pin,
  // Outputs
  output logic close_cmd,
  output logic inst_block,
  output logic [arc_pkg::NUM_STATUS-1:0] contact_out,
  output logic irq
);

  typedef struct packed {
    arc_pkg::arc_phase_t st;
    logic [2:0] shot;
    logic [arc_pkg::TMR_W-1:0] tmr;
    logic [31:0] tick_cnt;
    logic tick;
    logic svc;
    logic [1:0] shots_m1;
    logic policy;
    logic rel_src;
    logic [4:0] trip_blk;
    logic [2:0] pol;
    logic [3:0][arc_pkg::TMR_W-1:0] dead;
    logic [arc_pkg::TMR_W-1:0] ewin;
    logic [arc_pkg::TMR_W-1:0] reclaim;
    logic [arc_pkg::TMR_W-1:0] inhib;
    logic [19:0] stage_cfg;
    logic [arc_pkg::NUM_STATUS-1:0] route;
    logic [arc_pkg::NUM_STATUS-1:0] contacts;
    logic energy_alarm;
    logic [15:0] count;
    logic [arc_pkg::NUM_EVENTS-1:0] irq_st;
    logic [arc_pkg::NUM_EVENTS-1:0] irq_mask;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } arc_core_t;

  arc_core_t s_reg;
  arc_core_t s_next;
  logic [2:0] cin;
  logic energy_ok;
  logic blk;
  logic rel_in;
  logic start_any;
  logic veto_any;
  logic in_cycle;
  logic abort;
  logic expired;
  logic causes_gone;
  logic [arc_pkg::NUM_STATUS-1:0] stat_vec;

  ////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [9:0] choice(input logic [19:0] cfg, input logic [1:0] code);
    logic [9:0] m;
    m = '0;
    for (int i = 0; i < arc_pkg::NUM_STAGES; i++) begin
      m[i] = (cfg[i*2 +: 2] == code);
    end
    return m;
  endfunction : choice

  ////////////////////////////////////////////////////////////////
  // Contact conditioning
  arc_in_cond #(.WIDTH(3)) u_cond (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .raw({release_pin, block_pin, breaker_energy_ok_pin}),
    .pol(s_reg.pol),
    .asserted(cin)
  );

  assign energy_ok = cin[0];
  assign blk = cin[1];
  assign rel_in = cin[2];
  assign start_any = |(stage_trip & choice(s_reg.stage_cfg, arc_pkg::CH_START));
  assign veto_any = |(stage_trip & choice(s_reg.stage_cfg, arc_pkg::CH_VETO));
  assign in_cycle = (s_reg.st == arc_pkg::PH_TRIPPED) || (s_reg.st == arc_pkg::PH_DEAD) ||
                    (s_reg.st == arc_pkg::PH_WAIT) || (s_reg.st == arc_pkg::PH_CLOSING) ||
                    (s_reg.st == arc_pkg::PH_RECLAIM);
  assign abort = in_cycle && (blk || veto_any || !s_reg.svc);
  assign expired = (s_reg.tmr == '0);
  // Energy cause only counts while its alarm is still latched
  assign causes_gone = !blk && !start_any && !veto_any && (!s_reg.energy_alarm || energy_ok);

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic zero_cmd;
    logic ui_rel;
    logic [arc_pkg::NUM_EVENTS-1:0] w1c;
    logic [arc_pkg::NUM_EVENTS-1:0] ev;
    logic [31:0] wd;
    zero_cmd = 1'b0;
    ui_rel = 1'b0;
    w1c = '0;
    ev = '0;
    wd = '0;
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 32'h00000001;
    end
    if (s_reg.tick && !expired) begin
      s_next.tmr = s_reg.tmr - 20'h00001;
    end

    // Register write, once address and data are both held
    if (axi_req.awvalid && axi_rsp.awready) begin
      s_next.aw_held = 1'b1;
      s_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata = axi_req.wdata;
      s_next.wstrb = axi_req.wstrb;
    end
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = arc_pkg::RESP_OKAY;
      case ({s_reg.awaddr[7:2], 2'b00})
        arc_pkg::OFS_CTRL: begin
          wd = merge({19'h00000, s_reg.pol, s_reg.trip_blk, s_reg.rel_src, s_reg.policy, s_reg.shots_m1,
                      s_reg.svc}, s_reg.wdata, s_reg.wstrb);
          s_next.svc = wd[arc_pkg::CTRL_SVC];
          s_next.shots_m1 = wd[arc_pkg::CTRL_SHOTS +: 2];
          s_next.policy = wd[arc_pkg::CTRL_POLICY];
          s_next.rel_src = wd[arc_pkg::CTRL_RELSRC];
          s_next.trip_blk = wd[arc_pkg::CTRL_TRIPBLK +: 5];
          s_next.pol = wd[arc_pkg::CTRL_POL +: 3];
        end
        arc_pkg::OFS_CMD: begin
          wd = merge(32'h00000000, s_reg.wdata, s_reg.wstrb);
          zero_cmd = wd[arc_pkg::CMD_ZERO];
          ui_rel = wd[arc_pkg::CMD_RELEASE];
        end
        arc_pkg::OFS_STAT: begin
        end
        arc_pkg::OFS_COUNT: begin
        end
        arc_pkg::OFS_IRQ_ST: w1c = s_reg.wdata[arc_pkg::NUM_EVENTS-1:0] & {4{s_reg.wstrb[0]}};
        arc_pkg::OFS_IRQ_MASK: begin
          wd = merge({28'h0000000, s_reg.irq_mask}, s_reg.wdata, s_reg.wstrb);
          s_next.irq_mask = wd[arc_pkg::NUM_EVENTS-1:0];
        end
        arc_pkg::OFS_DEAD1, arc_pkg::OFS_DEAD2, arc_pkg::OFS_DEAD3, arc_pkg::OFS_DEAD4: begin
          wd = merge({12'h000, s_reg.dead[s_reg.awaddr[3:2] - 2'h2]}, s_reg.wdata, s_reg.wstrb);
          s_next.dead[s_reg.awaddr[3:2] - 2'h2] = wd[arc_pkg::TMR_W-1:0];
        end
        arc_pkg::OFS_EWIN: begin
          wd = merge({12'h000, s_reg.ewin}, s_reg.wdata, s_reg.wstrb);
          s_next.ewin = wd[arc_pkg::TMR_W-1:0];
        end
        arc_pkg::OFS_RECLAIM: begin
          wd = merge({12'h000, s_reg.reclaim}, s_reg.wdata, s_reg.wstrb);
          s_next.reclaim = wd[arc_pkg::TMR_W-1:0];
        end
        arc_pkg::OFS_INHIB: begin
          wd = merge({12'h000, s_reg.inhib}, s_reg.wdata, s_reg.wstrb);
          s_next.inhib = wd[arc_pkg::TMR_W-1:0];
        end
        arc_pkg::OFS_STAGE: begin
          wd = merge({12'h000, s_reg.stage_cfg}, s_reg.wdata, s_reg.wstrb);
          s_next.stage_cfg = wd[19:0];
        end
        arc_pkg::OFS_ROUTE: begin
          wd = merge({26'h0000000, s_reg.route}, s_reg.wdata, s_reg.wstrb);
          s_next.route = wd[arc_pkg::NUM_STATUS-1:0];
        end
        default: s_next.bresp = arc_pkg::RESP_SLVERR;
      endcase
    end

    // Register read
    if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = arc_pkg::RESP_OKAY;
      s_next.rdata = '0;
      case ({axi_req.araddr[7:2], 2'b00})
        arc_pkg::OFS_CTRL: s_next.rdata = {19'h00000, s_reg.pol, s_reg.trip_blk, s_reg.rel_src, s_reg.policy,
                                           s_reg.shots_m1, s_reg.svc};
        arc_pkg::OFS_CMD: s_next.rdata = '0;
        // Status bits not routed to a contact show here as monitor bits
        arc_pkg::OFS_STAT: s_next.rdata = {21'h000000, s_reg.shot, stat_vec & ~s_reg.route, 1'b0,
                                           s_reg.svc};
        arc_pkg::OFS_COUNT: s_next.rdata = {16'h0000, s_reg.count};
        arc_pkg::OFS_IRQ_ST: s_next.rdata = {28'h0000000, s_reg.irq_st};
        arc_pkg::OFS_IRQ_MASK: s_next.rdata = {28'h0000000, s_reg.irq_mask};
        arc_pkg::OFS_DEAD1, arc_pkg::OFS_DEAD2, arc_pkg::OFS_DEAD3, arc_pkg::OFS_DEAD4: begin
          s_next.rdata = {12'h000, s_reg.dead[axi_req.araddr[3:2] - 2'h2]};
        end
        arc_pkg::OFS_EWIN: s_next.rdata = {12'h000, s_reg.ewin};
        arc_pkg::OFS_RECLAIM: s_next.rdata = {12'h000, s_reg.reclaim};
        arc_pkg::OFS_INHIB: s_next.rdata = {12'h000, s_reg.inhib};
        arc_pkg::OFS_STAGE: s_next.rdata = {12'h000, s_reg.stage_cfg};
        arc_pkg::OFS_ROUTE: s_next.rdata = {26'h0000000, s_reg.route};
        default: s_next.rresp = arc_pkg::RESP_SLVERR;
      endcase
    end

    // Reclose sequence
    if (abort) begin
      s_next.st = arc_pkg::PH_LOCKOUT;
      ev[0] = 1'b1;
    end else begin
      case (s_reg.st)
        arc_pkg::PH_IDLE: begin
          // Breaker must have been closed up to the trip
          if (s_reg.svc && !blk && start_any && breaker_closed) begin
            s_next.st = arc_pkg::PH_TRIPPED;
            s_next.shot = 3'h0;
          end
        end
        arc_pkg::PH_TRIPPED: begin
          if (!start_any && breaker_open) begin
            s_next.st = arc_pkg::PH_DEAD;
            s_next.tmr = s_reg.dead[s_reg.shot[1:0]];
          end
        end
        arc_pkg::PH_DEAD: begin
          if (expired) begin
            s_next.st = arc_pkg::PH_WAIT;
            s_next.tmr = s_reg.ewin;
          end
        end
        arc_pkg::PH_WAIT: begin
          if (energy_ok) begin
            s_next.st = arc_pkg::PH_CLOSING;
          end else if (expired) begin
            s_next.st = arc_pkg::PH_LOCKOUT;
            s_next.energy_alarm = 1'b1;
            ev[0] = 1'b1;
            ev[1] = 1'b1;
          end
        end
        arc_pkg::PH_CLOSING: begin
          if (breaker_closed) begin
            s_next.st = arc_pkg::PH_RECLAIM;
            s_next.tmr = s_reg.reclaim;
            ev[3] = 1'b1;
          end
        end
        arc_pkg::PH_RECLAIM: begin
          if (start_any) begin
            if (s_reg.shot[1:0] == s_reg.shots_m1) begin
              s_next.st = arc_pkg::PH_LOCKOUT;
              ev[0] = 1'b1;
            end else begin
              s_next.st = arc_pkg::PH_TRIPPED;
              s_next.shot = s_reg.shot + 3'h1;
            end
          end else if (expired) begin
            s_next.st = arc_pkg::PH_IDLE;
            ev[2] = 1'b1;
          end
        end
        arc_pkg::PH_LOCKOUT: begin
          if (causes_gone && (rel_in || (!s_reg.rel_src && ui_rel) || (s_reg.rel_src && !s_reg.svc))) begin
            s_next.st = arc_pkg::PH_INHIBIT;
            s_next.tmr = s_reg.inhib;
            s_next.energy_alarm = 1'b0;
          end
        end
        arc_pkg::PH_INHIBIT: begin
          if (expired) begin
            s_next.st = arc_pkg::PH_IDLE;
          end
        end
        default: s_next.st = arc_pkg::PH_IDLE;
      endcase
    end

    // A zeroing command and an increment in the same cycle leave the count at one
    s_next.count = zero_cmd ? 16'h0000 : s_reg.count;
    if (ev[3]) begin
      s_next.count = s_next.count + 16'h0001;
    end
    s_next.irq_st = (s_reg.irq_st & ~w1c) | ev;
    s_next.contacts = stat_vec & s_reg.route;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.st <= arc_pkg::PH_IDLE;
      s_reg.svc <= 1'b1;
      s_reg.shots_m1 <= arc_pkg::RST_SHOTS_M1;
      s_reg.trip_blk <= arc_pkg::RST_TRIPBLK;
      s_reg.dead <= {arc_pkg::RST_DEAD4, arc_pkg::RST_DEAD3, arc_pkg::RST_DEAD2, arc_pkg::RST_DEAD1};
      s_reg.ewin <= arc_pkg::RST_EWIN;
      s_reg.reclaim <= arc_pkg::RST_RECLAIM;
      s_reg.inhib <= arc_pkg::RST_INHIB;
      s_reg.stage_cfg <= arc_pkg::RST_STAGE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign close_cmd = (s_reg.st == arc_pkg::PH_CLOSING);
  // Next trip is trip shot+2 inside a cycle, trip 1 otherwise
  assign inst_block = in_cycle ? (s_reg.trip_blk[s_reg.shot + 3'h1] ||
                                  (s_reg.policy && s_reg.shot[1:0] == s_reg.shots_m1)) : s_reg.trip_blk[0];
  assign stat_vec = {inst_block, s_reg.energy_alarm, s_reg.st == arc_pkg::PH_LOCKOUT, close_cmd,
                     s_reg.st == arc_pkg::PH_DEAD, in_cycle};
  assign contact_out = s_reg.contacts;
  assign irq = |(s_reg.irq_st & s_reg.irq_mask);
  assign axi_rsp = '{awready: !s_reg.aw_held && !s_reg.bvalid, wready: !s_reg.w_held && !s_reg.bvalid,
                     bvalid: s_reg.bvalid, bresp: s_reg.bresp, arready: !s_reg.rvalid, rvalid: s_reg.rvalid,
                     rdata: s_reg.rdata, rresp: s_reg.rresp};

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_energy_lock;
    (s_reg.st == arc_pkg::PH_WAIT) && expired && !energy_ok && !abort |=>
      (s_reg.st == arc_pkg::PH_LOCKOUT) && s_reg.energy_alarm && !close_cmd;
  endproperty
  a_energy_lock: assert property (p_energy_lock) else $error("no lockout after energy window");
  property p_block_lock;
    in_cycle && blk |=> (s_reg.st == arc_pkg::PH_LOCKOUT);
  endproperty
  a_block_lock: assert property (p_block_lock) else $error("block in cycle did not lock out");
  property p_release_hold;
    (s_reg.st == arc_pkg::PH_LOCKOUT) && !causes_gone |=> (s_reg.st == arc_pkg::PH_LOCKOUT);
  endproperty
  a_release_hold: assert property (p_release_hold) else $error("lockout left with cause present");
  property p_out_service;
    (s_reg.st == arc_pkg::PH_IDLE) && !s_reg.svc |=> (s_reg.st == arc_pkg::PH_IDLE);
  endproperty
  a_out_service: assert property (p_out_service) else $error("cycle started out of service");
  property p_count_inc;
    (s_reg.st == arc_pkg::PH_CLOSING) && breaker_closed && !abort && s_reg.count != 16'hffff |=>
      s_reg.count == $past(s_reg.count) + 16'h0001 || s_reg.count == 16'h0001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("reclose not counted");
  property p_inst_idle;
    (s_reg.st == arc_pkg::PH_IDLE) |-> (inst_block == s_reg.trip_blk[0]);
  endproperty
  a_inst_idle: assert property (p_inst_idle) else $error("trip 1 block wrong");
  property p_close_drop;
    close_cmd && breaker_closed |=> !close_cmd;
  endproperty
  a_close_drop: assert property (p_close_drop) else $error("close held after breaker closed");
  property p_last_shot;
    (s_reg.st == arc_pkg::PH_RECLAIM) && start_any && !abort && s_reg.shot[1:0] == s_reg.shots_m1 |=>
      (s_reg.st == arc_pkg::PH_LOCKOUT);
  endproperty
  a_last_shot: assert property (p_last_shot) else $error("shots exceeded without lockout");
  property p_shot_start;
    (s_reg.st == arc_pkg::PH_IDLE) ##1 (s_reg.st == arc_pkg::PH_TRIPPED) |-> (s_reg.shot == 3'h0);
  endproperty
  a_shot_start: assert property (p_shot_start) else $error("shot index not restarted");
  property p_tick_single;
    s_reg.tick |=> !s_reg.tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

  c_energy_lock: cover property ((s_reg.st == arc_pkg::PH_WAIT) ##1 s_reg.energy_alarm);
  c_success: cover property ((s_reg.st == arc_pkg::PH_RECLAIM) ##1 (s_reg.st == arc_pkg::PH_IDLE));
  c_second_shot: cover property ((s_reg.st == arc_pkg::PH_TRIPPED) && s_reg.shot == 3'h1);

endmodule : arc_core

// *** sim/arc_brk_model.sv ***
`timescale 1ns/10ps
module arc_brk_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Close command and trip coil
  input wire logic close_cmd,
  input wire logic open_req,
  // Auxiliary contacts
  output logic breaker_open,
  output logic breaker_closed
);
  logic [1:0] dly;
  assign breaker_open = !breaker_closed;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      breaker_closed <= 1'b1;
      dly <= 2'h0;
    end else if ((open_req && breaker_closed) || (close_cmd && !breaker_closed)) begin
      dly <= dly + 2'h1;
      // Mechanism travel: four cycles, so close_cmd must be held meanwhile
      if (dly == 2'h3) breaker_closed <= !breaker_closed;
    end else begin
      dly <= 2'h0;
    end
  end
endmodule : arc_brk_model

// *** sim/arc_core_tb.sv ***
`timescale 1ns/10ps
module arc_core_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  arc_pkg::arc_axi_req_t req = '0;
  arc_pkg::arc_axi_rsp_t rsp;
  logic [9:0] trip = '0;
  logic en_pin = 1'b0, blk_pin = 1'b0, open_req = 1'b0, rel_pin = 1'b0;
  logic bo, bc, close_cmd, inst_block, irq;
  logic [5:0] cout;
  logic [33:0] q[$];
  logic [31:0] rs = 32'd68;
  int n_mismatch = 0, num_checks = 0;
  bit closed_seen = 0;
  always #2 ref_clk = !ref_clk;
  arc_core #(.TICK_CYCLES(4)) arc_core_i (.ref_clk(ref_clk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
    .stage_trip(trip), .breaker_open(bo), .breaker_closed(bc), .breaker_energy_ok_pin(en_pin),
    .block_pin(blk_pin), .release_pin(rel_pin), .close_cmd(close_cmd), .inst_block(inst_block),
    .contact_out(cout), .irq(irq));
  arc_brk_model arc_brk_model_i (.ref_clk(ref_clk), .resetn(resetn), .close_cmd(close_cmd),
    .open_req(open_req), .breaker_open(bo), .breaker_closed(bc));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  // Responses are compared in order of completion, one transfer at a time
  always @(posedge ref_clk) begin
    if (close_cmd) closed_seen = 1;
    if (rsp.bvalid && req.bready) chk("bresp", {rsp.bresp, 32'h0}, q.pop_front());
    if (rsp.rvalid && req.rready) chk("rdata", {rsp.rresp, rsp.rdata}, q.pop_front());
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    q.push_back({(a > 8'h38) ? 2'h2 : 2'h0, 32'h0});
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= d; req.wstrb <= 4'hf;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (rsp.awready) begin aw = 1; req.awvalid <= 1'b0; end
      if (rsp.wready) begin w = 1; req.wvalid <= 1'b0; end
    end
    do @(posedge ref_clk); while (!rsp.bvalid);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d);
    q.push_back({(a > 8'h38) ? 2'h2 : 2'h0, d});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge ref_clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rsp.rvalid);
  endtask : rd
  task waitc(input int b, input logic v);
    int i;
    for (i = 0; i < 600 && cout[b] !== v; i++) @(posedge ref_clk);
    chk("contact", {33'h0, cout[b]}, {33'h0, v});
  endtask : waitc
  // Start stage trips, breaker opens, protection resets
  task cycle();
    int i;
    closed_seen = 0;
    trip <= 10'h1; open_req <= 1'b1;
    for (i = 0; i < 50 && !bo; i++) @(posedge ref_clk);
    trip <= 10'h0; open_req <= 1'b0;
  endtask : cycle
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [31:0] x;
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 32'h3c1);
    rd(8'h08, 32'h1);
    rd(8'h18, 32'h3e8);
    rd(8'h28, 32'h1f4);
    rd(8'h3c, 32'h0);
    chk("inst_block", {33'h0, inst_block}, 34'h0);
    x = xs() & 32'hfffff;
    wr(8'h1c, x);
    rd(8'h1c, x);
    wr(8'h18, 32'h2); wr(8'h28, 32'h2); wr(8'h2c, 32'h3); wr(8'h30, 32'h1);
    wr(8'h14, 32'hf); wr(8'h38, 32'h3f);
    en_pin <= 1'b1;
    cycle();
    waitc(1, 1);
    chk("inst_block", {33'h0, cout[5]}, 34'h1);
    waitc(2, 1);
    waitc(2, 0);
    waitc(0, 0);
    rd(8'h0c, 32'h1);
    rd(8'h10, 32'hc);
    chk("irq", {33'h0, irq}, 34'h1);
    wr(8'h10, 32'hf); wr(8'h04, 32'h1);
    rd(8'h0c, 32'h0);
    blk_pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    trip <= 10'h1;
    repeat (20) @(posedge ref_clk);
    chk("cycle", {33'h0, cout[0]}, 34'h0);
    trip <= 10'h0; blk_pin <= 1'b0; en_pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    cycle();
    waitc(3, 1);
    chk("alarm", {33'h0, cout[4]}, 34'h1);
    chk("closed", {33'h0, closed_seen}, 34'h0);
    wr(8'h04, 32'h2);
    rel_pin <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("lockout", {33'h0, cout[3]}, 34'h1);
    // Both pins pass the same filter, so the pin release never meets a cleared cause
    en_pin <= 1'b1;
    rel_pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    wr(8'h04, 32'h2);
    waitc(3, 0);
    wr(8'h00, 32'h3c0);
    rd(8'h08, 32'h0);
    conclude();
  end
endmodule : arc_core_tb
